/* File: uart_flow_defs.svh */
`ifndef UART_FLOW_DEFS_SVH
`define UART_FLOW_DEFS_SVH
// ======================================================
// register indices (byte address = 4 * index)
`define IDX_EFC 5'h00
`define IDX_RES1 5'h01
`define IDX_RES2 5'h02
`define IDX_STP1 5'h03
`define IDX_STP2 5'h04
`define IDX_IER 5'h05
`define IDX_ISR 5'h06
`define IDX_FCR 5'h07
`define IDX_MCR 5'h08
`define IDX_MSR 5'h09
`define IDX_TCR 5'h0A
`define IDX_TLR 5'h0B
`define IDX_FRAC 5'h0C
`define IDX_DIVL 5'h0D
`define IDX_DIVH 5'h0E
`define IDX_SCR 5'h0F
`define IDX_IOC 5'h10
// ======================================================
// reset values
`define RST_ZERO 8'h00
`define RST_TCR 8'h0F
`define RST_DIVL 8'h01
`define RST_DIVH 8'h00
`define RST_SCR 8'hFF
// ======================================================
// enhanced write masks and bit positions
`define MASK_IER_ENH 8'hF0
`define MASK_ISR_ENH 8'h30
`define MASK_FCR_ENH 8'h30
`define MASK_MCR_ENH 8'hE4
`define MASK_ALL 8'hFF
`define BIT_ENH 4
`define BIT_SPEC 5
`define BIT_ARTS 6
`define BIT_ACTS 7
`define BIT_ISR_SPEC 4
`define BIT_ISR_STOP 5
`define BIT_IER_SPEC 5
`define BIT_MCR_RTS 1
`define BIT_IOC_SRST 3
`define MODE_NONE 2'h0
`define MODE_SECOND 2'h1
`define MODE_FIRST 2'h2
`define MODE_BOTH 2'h3
`endif

/* File: uart_flow_pkg.sv */
package uart_flow_pkg;
   // ======================================================
   // bus request and character carriers
   typedef struct packed {
      logic read;
      logic write;
      logic [6:0] address;
      logic [31:0] writedata;
   } av_req_t;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } char_t;
   typedef enum {SEND_IDLE, SEND_FIRST, SEND_SECOND} send_state_t;
endpackage

/* File: uart_flow_control_features.sv */
// Overview of operation
// - efr bits 3:2 pick transmit flow chars: none, first, second, or both sequentially.
// - efr bits 1:0 pick receive compare; 11 with single tx accepts either pair.
// - receive 11 with transmit 11 or 00 needs both chars as a sequential pair.
// - flow-control select bits are zero after reset.
// - enhanced register bits change only while enhanced enable bit 4 is one.
// - clearing enhanced enable freezes enhanced settings until it is set again.
// - special detect stores a char matching stop_char_second and sets status bit 4.
// - special detect and first-pair compare work independently.
// - with second-pair compare, stop_char_second is dropped; special flag needs enable bit 5.
// - auto rts raises request line at halt level, lowers it below resume level.
// - auto rts acts only once the request bit asserts the line low.
// - without auto rts, the request line follows its control bit.
// - auto cts stops transmission while clear-to-send is high.
// - four flow character registers load zero at power-up only.
// - divisor high byte powers up 0x00, low byte 0x01.
// - on reset modem status delta bits clear; upper bits show inverted inputs.
// - divisor, scratch and flow chars survive pin and software reset.
// - dual mode treats each pair as two consecutive line characters.
`timescale 1ns/10ps
`default_nettype none
`include "uart_flow_defs.svh"
module uart_flow_control_features (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_power_on_rst,
   input wire uart_flow_pkg::av_req_t i_av,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   input wire uart_flow_pkg::char_t i_rx,
   input wire logic [6:0] i_rx_fill,
   output uart_flow_pkg::char_t o_push,
   output uart_flow_pkg::char_t o_flow,
   input wire logic i_flow_ready,
   output logic o_tx_allow,
   input wire logic i_cts_n,
   input wire logic [3:0] i_modem_n,
   output logic o_rts_n,
   output logic o_rx_trigger
);
   // ======================================================
   // helpers
   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                        input logic [7:0] mask);
      merge = (old & ~mask) | (nw & mask);
   endfunction
   function automatic logic [6:0] level(input logic [3:0] x);
      level = {1'b0, x, 2'b00};
   endfunction

   // ======================================================
   // registers
   logic [7:0] efc, res1, res2, stp1, stp2, interrupt_enable_reg, interrupt_status_reg, fifo_control_reg, modem_control_reg, msr_delta;
   logic [7:0] trigger_control_reg, trigger_level_reg, frac, divl, divh, scr;
   logic [2:0] ioc;
   logic soft_rst;
   logic [1:0] cts_sync;
   logic [3:0] modem_s1, modem_s2, modem_old;
   logic pend_on, pend_off, sw_halt, rts_halted, stop_sent;
   uart_flow_pkg::send_state_t state;
   logic [7:0] second_char;

   wire rst_all = i_rst | soft_rst | i_power_on_rst;
   wire req = i_av.read | i_av.write;
   wire take = req & o_waitrequest;
   wire wr = i_av.write & ~o_waitrequest;
   wire rd = i_av.read & ~o_waitrequest;
   wire [4:0] idx = i_av.address[6:2];
   wire [7:0] wd = i_av.writedata[7:0];
   wire enh = efc[`BIT_ENH];
   wire [7:0] enh_mask_all = enh ? `MASK_ALL : `RST_ZERO;
   wire cts_high = cts_sync[1];

   // ======================================================
   // bus slave: one wait cycle, then a one-cycle answer
   always_ff @(posedge i_clock) begin
      if (rst_all) begin
         o_waitrequest <= 1'b1;
      end else begin
         o_waitrequest <= ~take;
      end
   end

   logic [7:0] rdata;
   always_comb begin
      if (idx == `IDX_EFC) rdata = efc;
      else if (idx == `IDX_RES1) rdata = res1;
      else if (idx == `IDX_RES2) rdata = res2;
      else if (idx == `IDX_STP1) rdata = stp1;
      else if (idx == `IDX_STP2) rdata = stp2;
      else if (idx == `IDX_IER) rdata = interrupt_enable_reg;
      else if (idx == `IDX_ISR) rdata = interrupt_status_reg;
      else if (idx == `IDX_FCR) rdata = fifo_control_reg;
      else if (idx == `IDX_MCR) rdata = modem_control_reg;
      else if (idx == `IDX_MSR) rdata = {~modem_s2, msr_delta[3:0]};
      else if (idx == `IDX_TCR) rdata = trigger_control_reg;
      else if (idx == `IDX_TLR) rdata = trigger_level_reg;
      else if (idx == `IDX_FRAC) rdata = frac;
      else if (idx == `IDX_DIVL) rdata = divl;
      else if (idx == `IDX_DIVH) rdata = divh;
      else if (idx == `IDX_SCR) rdata = scr;
      else if (idx == `IDX_IOC) rdata = {4'h0, soft_rst, ioc};
      else rdata = `RST_ZERO;
   end

   always_ff @(posedge i_clock) begin
      if (rst_all) begin
         o_readdata <= 32'h0000_0000;
      end else if (take) begin
         o_readdata <= {24'h00_0000, rdata};
      end
   end

   // ======================================================
   // input synchronisers
   always_ff @(posedge i_clock) begin
      cts_sync <= {cts_sync[0], i_cts_n};
      modem_s1 <= i_modem_n;
      modem_s2 <= modem_s1;
   end

   // ======================================================
   // power-up-only registers
   wire w_res1 = wr & (idx == `IDX_RES1);
   wire w_res2 = wr & (idx == `IDX_RES2);
   wire w_stp1 = wr & (idx == `IDX_STP1);
   wire w_stp2 = wr & (idx == `IDX_STP2);
   always_ff @(posedge i_clock) begin
      if (i_power_on_rst) begin
         res1 <= `RST_ZERO;
         res2 <= `RST_ZERO;
         stp1 <= `RST_ZERO;
         stp2 <= `RST_ZERO;
         divl <= `RST_DIVL;
         divh <= `RST_DIVH;
         scr <= `RST_SCR;
      end else if (wr) begin
         if (w_res1) res1 <= wd;
         if (w_res2) res2 <= wd;
         if (w_stp1) stp1 <= wd;
         if (w_stp2) stp2 <= wd;
         if (idx == `IDX_DIVL) divl <= wd;
         if (idx == `IDX_DIVH) divh <= wd;
         if (idx == `IDX_SCR) scr <= wd;
      end
   end

   // ======================================================
   // control registers with enhanced write gate
   wire [7:0] next_ier = merge(interrupt_enable_reg, wd, `MASK_ALL & ~(`MASK_IER_ENH & ~enh_mask_all));
   wire [7:0] next_fcr = merge(fifo_control_reg, wd, `MASK_ALL & ~(`MASK_FCR_ENH & ~enh_mask_all));
   wire [7:0] next_mcr = merge(modem_control_reg, wd, `MASK_ALL & ~(`MASK_MCR_ENH & ~enh_mask_all));
   wire w_tcr = wr & (idx == `IDX_TCR);
   always_ff @(posedge i_clock) begin
      if (rst_all) begin
         efc <= `RST_ZERO;
         interrupt_enable_reg <= `RST_ZERO;
         fifo_control_reg <= `RST_ZERO;
         modem_control_reg <= `RST_ZERO;
         trigger_control_reg <= `RST_TCR;
         trigger_level_reg <= `RST_ZERO;
         frac <= `RST_ZERO;
         ioc <= 3'h0;
      end else if (wr) begin
         if (idx == `IDX_EFC) efc <= wd;
         if (idx == `IDX_IER) interrupt_enable_reg <= next_ier;
         if (idx == `IDX_FCR) fifo_control_reg <= next_fcr;
         if (idx == `IDX_MCR) modem_control_reg <= next_mcr;
         if (w_tcr) trigger_control_reg <= merge(trigger_control_reg, wd, enh_mask_all);
         if (idx == `IDX_TLR) trigger_level_reg <= merge(trigger_level_reg, wd, enh_mask_all);
         if (idx == `IDX_FRAC) frac <= merge(frac, wd, enh_mask_all);
         if (idx == `IDX_IOC) ioc <= wd[2:0];
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst | i_power_on_rst) begin
         soft_rst <= 1'b0;
      end else begin
         soft_rst <= wr & (idx == `IDX_IOC) & wd[`BIT_IOC_SRST] & ~soft_rst;
      end
   end

   // ======================================================
   // modem status deltas, cleared by read, set wins
   wire [3:0] modem_chg = modem_s2 ^ modem_old;
   wire rd_msr = rd & (idx == `IDX_MSR);
   always_ff @(posedge i_clock) begin
      modem_old <= modem_s2;
      if (rst_all) begin
         msr_delta <= `RST_ZERO;
      end else begin
         msr_delta <= {4'h0, modem_chg | (msr_delta[3:0] & {4{~rd_msr}})};
      end
   end

   // ======================================================
   // receive compare
   wire [1:0] rx_mode = efc[1:0];
   wire [1:0] tx_mode = efc[3:2];
   wire [7:0] ch = i_rx.data;
   wire on1 = ch == res1;
   wire on2 = ch == res2;
   wire off1 = ch == stp1;
   wire off2 = ch == stp2;
   wire seq = (rx_mode == `MODE_BOTH) & ((tx_mode == `MODE_BOTH) | (tx_mode == `MODE_NONE));
   wire on_single = (rx_mode == `MODE_FIRST) ? on1 :
                    (rx_mode == `MODE_SECOND) ? on2 :
                    (rx_mode == `MODE_BOTH) ? (on1 | on2) : 1'b0;
   wire off_single = (rx_mode == `MODE_FIRST) ? off1 :
                     (rx_mode == `MODE_SECOND) ? off2 :
                     (rx_mode == `MODE_BOTH) ? (off1 | off2) : 1'b0;
   wire resume_hit = seq ? (pend_on & on2) : on_single;
   wire stop_hit = seq ? (pend_off & off2) : off_single;
   wire resume_evt = i_rx.valid & resume_hit;
   wire stop_evt = i_rx.valid & stop_hit;
   wire spec = efc[`BIT_SPEC] & off2;
   wire spec_second = spec & (rx_mode == `MODE_SECOND);
   wire keep_char = ~(resume_hit | stop_hit) | (spec & ~spec_second);
   wire set_spec = i_rx.valid & spec & (~spec_second | interrupt_enable_reg[`BIT_IER_SPEC]);
   wire clr_isr = wr & (idx == `IDX_ISR) & enh;

   always_ff @(posedge i_clock) begin
      if (rst_all) begin
         pend_on <= 1'b0;
         pend_off <= 1'b0;
         o_push <= '0;
         interrupt_status_reg <= `RST_ZERO;
      end else begin
         if (i_rx.valid) begin
            pend_on <= on1 & ~resume_hit;
            pend_off <= off1 & ~stop_hit;
         end
         o_push.valid <= i_rx.valid & keep_char;
         o_push.data <= ch;
         interrupt_status_reg[`BIT_ISR_SPEC] <= set_spec | (interrupt_status_reg[`BIT_ISR_SPEC] & ~(clr_isr & wd[`BIT_ISR_SPEC]));
         interrupt_status_reg[`BIT_ISR_STOP] <= stop_evt | (interrupt_status_reg[`BIT_ISR_STOP] & ~(clr_isr & wd[`BIT_ISR_STOP]));
      end
   end

   // ======================================================
   // transmit gating
   always_ff @(posedge i_clock) begin
      if (rst_all | (rx_mode == `MODE_NONE)) begin
         sw_halt <= 1'b0;
      end else if (stop_evt) begin
         sw_halt <= 1'b1;
      end else if (resume_evt) begin
         sw_halt <= 1'b0;
      end
   end

   wire next_halt = stop_evt | (sw_halt & ~resume_evt & (rx_mode != `MODE_NONE));
   always_ff @(posedge i_clock) begin
      if (rst_all) begin
         o_tx_allow <= 1'b1;
      end else begin
         o_tx_allow <= ~next_halt & ~(efc[`BIT_ACTS] & cts_high);
      end
   end

   // ======================================================
   // auto request-to-send and trigger
   wire [6:0] halt_lvl = level(trigger_control_reg[3:0]);
   wire [6:0] resume_lvl = level(trigger_control_reg[7:4]);
   wire [6:0] trig_lvl = (trigger_level_reg[7:4] == 4'h0) ? 7'h01 : level(trigger_level_reg[7:4]);
   wire above_halt = i_rx_fill >= halt_lvl;
   wire below_resume = i_rx_fill < resume_lvl;
   always_ff @(posedge i_clock) begin
      if (rst_all) begin
         rts_halted <= 1'b0;
         o_rts_n <= 1'b1;
         o_rx_trigger <= 1'b0;
      end else begin
         if (above_halt) rts_halted <= 1'b1;
         else if (below_resume) rts_halted <= 1'b0;
         o_rts_n <= ~(modem_control_reg[`BIT_MCR_RTS] & ~(efc[`BIT_ARTS] & rts_halted));
         o_rx_trigger <= efc[`BIT_ARTS] & (i_rx_fill >= trig_lvl);
      end
   end

   // ======================================================
   // transmit flow characters
   wire need_stop = (tx_mode != `MODE_NONE) & above_halt & ~stop_sent;
   wire need_resume = stop_sent & below_resume;
   wire [7:0] first_char = need_stop ? ((tx_mode == `MODE_SECOND) ? stp2 : stp1) :
                                       ((tx_mode == `MODE_SECOND) ? res2 : res1);
   always_ff @(posedge i_clock) begin
      if (rst_all) begin
         state <= uart_flow_pkg::SEND_IDLE;
         o_flow <= '0;
         stop_sent <= 1'b0;
         second_char <= `RST_ZERO;
      end else begin
         case (state)
            uart_flow_pkg::SEND_IDLE: begin
               if (tx_mode == `MODE_NONE) begin
                  stop_sent <= 1'b0;
               end else if (need_stop | need_resume) begin
                  stop_sent <= need_stop;
                  o_flow.valid <= 1'b1;
                  o_flow.data <= first_char;
                  second_char <= need_stop ? stp2 : res2;
                  state <= uart_flow_pkg::SEND_FIRST;
               end
            end
            uart_flow_pkg::SEND_FIRST: begin
               if (i_flow_ready) begin
                  if (tx_mode == `MODE_BOTH) begin
                     o_flow.data <= second_char;
                     state <= uart_flow_pkg::SEND_SECOND;
                  end else begin
                     o_flow.valid <= 1'b0;
                     state <= uart_flow_pkg::SEND_IDLE;
                  end
               end
            end
            default: begin
               if (i_flow_ready) begin
                  o_flow.valid <= 1'b0;
                  state <= uart_flow_pkg::SEND_IDLE;
               end
            end
         endcase
      end
   end

   // ======================================================
   // checks
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (rst_all);

   sequence s_ack;
      !o_waitrequest ##1 o_waitrequest;
   endsequence

   a_bus_ack: assert property (take |=> s_ack)
      else $error("bus answer not one cycle");
   a_cts_stop: assert property (efc[`BIT_ACTS] && cts_high |=> !o_tx_allow)
      else $error("transmit allowed while cts high");
   a_stop_halt: assert property (stop_evt |=> !o_tx_allow ##0 sw_halt)
      else $error("stop char did not halt");
   a_rts_plain: assert property (!efc[`BIT_ARTS] |=> o_rts_n == !$past(modem_control_reg[1]))
      else $error("rts not following control bit");
   a_enh_lock: assert property (w_tcr && !enh |=> trigger_control_reg == $past(trigger_control_reg))
      else $error("tcr changed while locked");
   a_spec_store: assert property (i_rx.valid && spec && rx_mode == `MODE_FIRST
                                  |=> o_push.valid && interrupt_status_reg[4])
      else $error("special char not stored");
   a_spec_drop: assert property (i_rx.valid && spec_second |=> !o_push.valid)
      else $error("second stop char stored");
   a_seq_pair: assert property (seq && pend_off && i_rx.valid && off2
                                |=> sw_halt)
      else $error("sequential stop pair missed");
   a_rts_auto: assert property (efc[`BIT_ARTS] && modem_control_reg[1] && above_halt |=> ##1 o_rts_n)
      else $error("auto rts did not halt");
endmodule
`default_nettype wire

/* File: uart_flow_peer.sv */
`timescale 1ns/10ps
`default_nettype none
module uart_flow_peer (
   input wire logic i_clock,
   input wire uart_flow_pkg::char_t i_flow,
   input wire logic [3:0] i_slow,
   output var uart_flow_pkg::char_t o_rx,
   output var logic o_flow_ready,
   output var logic o_cts_n,
   output var logic [3:0] o_modem_n
);
   // ======================================================
   // far-side line partner: sends characters, takes flow characters
   logic [7:0] got_q[$];
   logic [3:0] cnt;
   initial begin
      o_rx = '0;
      o_flow_ready = 1'b0;
      o_cts_n = 1'b0;
      o_modem_n = 4'hA;
      cnt = 4'h0;
   end
   always @(posedge i_clock) begin
      if (o_flow_ready && i_flow.valid) begin
         got_q.push_back(i_flow.data);
         o_flow_ready <= 1'b0;
         cnt <= 4'h0;
      end else if (i_flow.valid) begin
         o_flow_ready <= (cnt >= i_slow);
         cnt <= cnt + 4'h1;
      end
   end
   task automatic send(input logic [7:0] c);
      @(posedge i_clock);
      o_rx <= '{valid: 1'b1, data: c};
      @(posedge i_clock);
      o_rx <= '{valid: 1'b0, data: ~c};
   endtask
   task automatic set_cts(input logic v);
      @(posedge i_clock);
      o_cts_n <= v;
   endtask
endmodule
`default_nettype wire

/* File: uart_flow_control_features_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "uart_flow_defs.svh"
module uart_flow_control_features_bench;
   // ======================================================
   // clock, design and partner
   logic clk, rst, por, wreq, tx_allow, fready, cts_n, rts_n, rx_trig;
   logic [31:0] rd_data, seed;
   logic [6:0] fill;
   logic [3:0] modem_n, slow;
   logic [7:0] q, e, base;
   uart_flow_pkg::av_req_t av;
   uart_flow_pkg::char_t rx, push, flow;
   logic [7:0] m [0:31];
   logic [7:0] exp_q[$];
   logic [7:0] fq[$];
   logic [7:0] txm [3] = '{8'h18, 8'h14, 8'h1C};
   logic [15:0] rxs [9] = '{16'h0012, 16'h0011, 16'h0017, 16'h001B, 16'h0013, 16'h001F,
      16'h0032, 16'h0031, 16'h2031};
   logic [4:0] enh [5] = '{`IDX_IER, `IDX_MCR, `IDX_TCR, `IDX_TLR, `IDX_FRAC};
   logic [4:0] keep [8] = '{5'h01, 5'h02, 5'h03, 5'h04, `IDX_DIVL, `IDX_DIVH, `IDX_SCR, `IDX_EFC};
   int seq [10] = '{0, 3, 4, 0, 1, 2, 4, 0, 2, 3};
   int bad_count, checked, halted, pend, hh;
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   uart_flow_control_features u_dut (.i_clock(clk), .i_rst(rst), .i_power_on_rst(por),
      .i_av(av), .o_readdata(rd_data), .o_waitrequest(wreq), .i_rx(rx), .i_rx_fill(fill),
      .o_push(push), .o_flow(flow), .i_flow_ready(fready), .o_tx_allow(tx_allow),
      .i_cts_n(cts_n), .i_modem_n(modem_n), .o_rts_n(rts_n), .o_rx_trigger(rx_trig));
   uart_flow_peer u_peer (.i_clock(clk), .i_flow(flow), .i_slow(slow), .o_rx(rx),
      .o_flow_ready(fready), .o_cts_n(cts_n), .o_modem_n(modem_n));
   // ======================================================
   // model and helpers
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   task automatic mreset(input bit pw);
      for (int i = 0; i < 32; i++)
         if (pw || !(i inside {1, 2, 3, 4, 13, 14, 15}))
            m[i] = 8'h00;
      m[`IDX_TCR] = 8'h0F;
      m[`IDX_MSR] = {~modem_n, 4'h0};
      if (pw) begin
         m[`IDX_DIVL] = 8'h01;
         m[`IDX_SCR] = 8'hFF;
      end
      halted = 0;
      hh = 0;
   endtask
   task automatic bus(input logic w, input logic [4:0] i, input logic [7:0] d, output logic [7:0] r);
      int n;
      n = 0;
      @(posedge clk);
      av <= '{read: !w, write: w, address: {i, 2'b00}, writedata: {24'h0, d}};
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      if (n >= 50) bad_count++;
      r = rd_data[7:0];
      av <= '0;
   endtask
   task automatic wr(input logic [4:0] i, input logic [7:0] d);
      logic [7:0] mk;
      case (i)
         `IDX_IER: mk = 8'hF0;
         `IDX_MCR: mk = 8'hE4;
         `IDX_TCR, `IDX_TLR, `IDX_FRAC: mk = 8'hFF;
         default: mk = 8'h00;
      endcase
      if (m[`IDX_EFC][4]) mk = 8'h00;
      bus(1'b1, i, d, q);
      if (i == `IDX_ISR) begin
         if (m[`IDX_EFC][4]) m[i] = m[i] & ~d;
      end else if (i < `IDX_IOC) m[i] = (m[i] & mk) | (d & ~mk);
      if (i == `IDX_EFC && d[1:0] == 2'b00) halted = 0;
   endtask
   task automatic rd(input logic [4:0] i);
      bus(1'b0, i, 8'h00, q);
      cmp(i == `IDX_ISR ? q & 8'h30 : q, m[i]);
   endtask
   task automatic flow_set(input logic [7:0] v);
      wr(`IDX_EFC, v & 8'hF0);
      wr(`IDX_EFC, v);
   endtask
   task automatic setfill(input logic [6:0] f);
      logic [6:0] trig;
      @(posedge clk);
      fill <= f;
      if (f >= 7'(m[`IDX_TCR][3:0]) * 4) hh = 1;
      else if (f < 7'(m[`IDX_TCR][7:4]) * 4) hh = 0;
      trig = m[`IDX_TLR][7:4] == 4'h0 ? 7'h01 : 7'(m[`IDX_TLR][7:4]) * 4;
      repeat (4) @(posedge clk);
      cmp({7'h0, rts_n}, 8'(!(m[`IDX_MCR][1] && !(m[0][6] && hh))));
      cmp({7'h0, rx_trig}, 8'(m[0][6] && f >= trig));
   endtask
   task automatic rxc(input int sel);
      logic [7:0] c;
      int rm, tm, st, rs, any;
      c = sel == 0 ? m[1] + 8'h08 + rnd() % 8'hC8 : m[sel];
      rm = m[0][1:0];
      tm = m[0][3:2];
      any = rm == 3 && (tm == 1 || tm == 2);
      st = (rm == 2 || any) && c == m[3] || (rm == 1 || any) && c == m[4];
      rs = (rm == 2 || any) && c == m[1] || (rm == 1 || any) && c == m[2];
      if (rm == 3 && !any) begin
         st = pend == 1 && c == m[4];
         rs = pend == 2 && c == m[2];
      end
      pend = c == m[3] ? 1 : c == m[1] ? 2 : 0;
      if (st) halted = 1;
      if (rs) halted = 0;
      if (st) m[`IDX_ISR][5] = 1'b1;
      if (m[0][5] && c == m[4] && !(rm == 1 && !m[`IDX_IER][5])) m[`IDX_ISR][4] = 1'b1;
      if (!st && !rs) exp_q.push_back(c);
      u_peer.send(c);
      repeat (2) @(posedge clk);
      cmp({7'h0, tx_allow}, 8'(halted == 0));
   endtask
   always @(posedge clk) begin
      if (push.valid === 1'b1) begin
         if (exp_q.size() == 0) cmp(push.data, ~push.data);
         else cmp(push.data, exp_q.pop_front());
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      bad_count++;
      end_sim();
   end
   // ======================================================
   // test sequence
   initial begin
      seed = 32'hD34D;
      rst = 1'b1;
      por = 1'b1;
      av = '0;
      fill = 7'h00;
      slow = 4'h0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      por <= 1'b0;
      mreset(1'b1);
      for (int i = 0; i < 16; i++) rd(5'(i));
      wr(5'h1F, 8'h5A);
      rd(5'h1F);
      done("reset values");
      base = rnd();
      foreach (keep[j]) wr(keep[j], rnd());
      for (int i = 1; i < 5; i++) wr(5'(i), base + 8'(i - 1));
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      mreset(1'b0);
      foreach (keep[j]) rd(keep[j]);
      wr(`IDX_EFC, 8'h1A);
      bus(1'b1, `IDX_IOC, 8'h08, q);
      mreset(1'b0);
      repeat (4) @(posedge clk);
      foreach (keep[j]) rd(keep[j]);
      rd(`IDX_TCR);
      done("reset retention");
      foreach (enh[k]) begin
         wr(`IDX_EFC, 8'h00);
         wr(enh[k], rnd());
         rd(enh[k]);
         wr(`IDX_EFC, 8'h10);
         wr(enh[k], rnd());
         rd(enh[k]);
         wr(`IDX_EFC, 8'h00);
         wr(enh[k], rnd());
         rd(enh[k]);
      end
      done("enhanced gate");
      wr(`IDX_EFC, 8'h10);
      wr(`IDX_TCR, 8'h12);
      wr(`IDX_TLR, 8'h20);
      wr(`IDX_MCR, 8'h02);
      foreach (txm[k]) begin
         flow_set(txm[k]);
         slow <= 4'(rnd() % 4);
         if (txm[k][3]) fq.push_back(m[3]);
         if (txm[k][2]) fq.push_back(m[4]);
         if (txm[k][3]) fq.push_back(m[1]);
         if (txm[k][2]) fq.push_back(m[2]);
         setfill(7'd10);
         repeat (30) @(posedge clk);
         setfill(7'd2);
         repeat (30) @(posedge clk);
         while (fq.size() > 0) begin
            e = fq.pop_front();
            cmp(u_peer.got_q.size() > 0 ? u_peer.got_q.pop_front() : ~e, e);
         end
         cmp(8'(u_peer.got_q.size()), 8'h00);
      end
      done("flow send");
      foreach (rxs[k]) begin
         wr(`IDX_IER, rxs[k][15:8]);
         flow_set(rxs[k][7:0]);
         foreach (seq[j]) rxc(seq[j]);
         rd(`IDX_ISR);
         wr(`IDX_ISR, 8'h30);
         rd(`IDX_ISR);
      end
      repeat (4) @(posedge clk);
      cmp(8'(exp_q.size()), 8'h00);
      done("receive compare");
      wr(`IDX_MCR, 8'h00);
      flow_set(8'h50);
      setfill(7'd2);
      wr(`IDX_MCR, 8'h02);
      setfill(7'd10);
      setfill(7'd6);
      setfill(7'd3);
      flow_set(8'h10);
      setfill(7'd10);
      wr(`IDX_MCR, 8'h00);
      setfill(7'd10);
      done("auto request");
      for (int k = 0; k < 2; k++) begin
         flow_set(k == 1 ? 8'h90 : 8'h10);
         u_peer.set_cts(1'b1);
         repeat (5) @(posedge clk);
         cmp({7'h0, tx_allow}, 8'(k == 0));
         u_peer.set_cts(1'b0);
         repeat (5) @(posedge clk);
         cmp({7'h0, tx_allow}, 8'h01);
      end
      done("auto clear");
      end_sim();
   end
endmodule
`default_nettype wire
